// [hdl/adc_cfg_defines.vh]
`ifndef ADC_CFG_DEFINES_VH
`define ADC_CFG_DEFINES_VH
// ****************************************************************
// Register indexes (byte address is four times the index)
// ****************************************************************
`define IDX_LIMIT_HIGH   4'h7
`define IDX_LIMIT_LOW    4'h8
`define IDX_SETUP        4'h9
`define IDX_TRIM_HIGH    4'hA
`define IDX_TRIM_LOW     4'hB
`define IDX_W            4
`define IDX_LSB          2
`define IDX_MSB          5
`define ALIGN_BITS       1:0
`define ADDR_TOP_LSB     6
// ****************************************************************
// Field positions
// ****************************************************************
`define F_WORD           15:0
`define F_LIMIT_LOWER    15:8
`define F_LIMIT_RSVD     7:4
`define F_COEFF          3:0
`define F_SKEW           15:6
`define F_SETUP_RSVD     5:3
`define F_REMOVAL_OFF    2
`define F_INPUT_SEL      1:0
`define F_TRIM_LOWER     15:8
`define F_TRIM_RSVD      7:0
`define F_LANE0          7:0
`define F_LANE1          15:8
// ****************************************************************
// Reset values and constants
// ****************************************************************
`define RST_WORD         16'h0000
`define RST_BYTE         8'h00
`define RST_COEFF        4'h0
`define RST_SKEW         10'h000
`define RST_SEL          2'h0
`define RST_BUS          32'h0000_0000
`define COEFF_OFF        4'h0
`define SHIFT_BASE       5'h01
`define SHIFT_NONE       5'h00
`define ONEHOT_RST       4'h1
`endif

// [hdl/apb_access_ctrl.v]
`default_nettype none
`include "adc_cfg_defines.vh"
// ****************************************************************
// APB access control: one wait state, address decode, error answer
// ****************************************************************
module apb_access_ctrl #(
  parameter ADDR_W = 8
) (
  input  wire              clk,
  input  wire              arst_n,
  input  wire              clk_en,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  output reg               pready_r,
  output reg               pslverr_r,
  output wire              wr_en,
  output wire              rd_en,
  output wire              hit,
  output wire [`IDX_W-1:0] idx
);

  // Index holds one of the five mapped registers
  function idx_mapped;
    input [`IDX_W-1:0] i;
    begin
      idx_mapped = (i >= `IDX_LIMIT_HIGH) && (i <= `IDX_TRIM_LOW);
    end
  endfunction

  wire access_ph;  // Access phase of a transfer

  assign idx       = paddr[`IDX_MSB:`IDX_LSB];
  assign hit       = (paddr[`ALIGN_BITS] == 2'h0) && ~|(paddr >> `ADDR_TOP_LSB)
                     && idx_mapped(idx);
  assign access_ph = psel & penable;
  // Write lands on the edge that samples pready high
  assign wr_en     = access_ph & pready_r & pwrite & hit;
  // Read data is latched one edge before pready is seen
  assign rd_en     = access_ph & ~pready_r & ~pwrite;

  // Ready flop high for exactly the final access cycle; error flop too when the address misses
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else if (clk_en)
    begin
      pready_r  <= access_ph & ~pready_r;
      pslverr_r <= access_ph & ~pready_r & ~hit;
    end
  end
endmodule // apb_access_ctrl
`default_nettype wire

// [hdl/channel_filter_decode.v]
`default_nettype none
// ****************************************************************
// Effective offset-removal filter and input selection, channel 0
// ****************************************************************
module channel_filter_decode (
  input  wire       clk,
  input  wire       arst_n,
  input  wire       clk_en,
  input  wire [3:0] coeff,
  input  wire       removal_off,
  input  wire [1:0] input_sel,
  output reg        filter_on_r,
  output reg  [4:0] filter_shift_r,
  output reg  [3:0] sel_onehot_r
);
`include "adc_cfg_defines.vh"

  wire       on_nxt;     // Filter active for this channel
  wire [4:0] shift_nxt;  // Coefficient is 2 to the minus shift

  // Code zero disables, else 1/4 halving per step; channel bit overrides
  assign on_nxt    = (coeff != `COEFF_OFF) & ~removal_off;
  assign shift_nxt = on_nxt ? ({1'b0, coeff} + `SHIFT_BASE) : `SHIFT_NONE;

  // Decoded flops: one cycle behind the register fields
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      filter_on_r    <= 1'b0;
      filter_shift_r <= `SHIFT_NONE;
      sel_onehot_r   <= `ONEHOT_RST;
    end
    else if (clk_en)
    begin
      filter_on_r    <= on_nxt;
      filter_shift_r <= shift_nxt;
      sel_onehot_r   <= `ONEHOT_RST << input_sel;
    end
  end
endmodule // channel_filter_decode
`default_nettype wire

// [hdl/adc_cfg_regs.v]
// Overview of operation
// - Threshold high word register, index 7h, zero reset
// - Index 8h: threshold low byte, reserved 7:4
// - Coefficient code zero off, else quarter halving
// - Channel setup register index 9h, zero reset
// - Bits 15:6 hold signed sample skew
// - Channel bit two turns filter off locally
// - Bits 1:0 select pins, short, test signals
// - Index Ah holds zero trim bits 23:8
// - Index Bh holds zero trim low word
// - Trim low byte in 15:8, 7:0 read zero
//
// The implementer's own choice: the APB register port.
`default_nettype none
module adc_cfg_regs #(
  parameter ADDR_W = 8
) (
  input  wire              MCLK,
  input  wire              ARST_N,
  input  wire              CLK_EN,
  input  wire              PSEL,
  input  wire              PENABLE,
  input  wire              PWRITE,
  input  wire [ADDR_W-1:0] PADDR,
  input  wire [31:0]       PWDATA,
  input  wire [3:0]        PSTRB,
  output reg  [31:0]       PRDATA,
  output wire              PREADY,
  output wire              PSLVERR,
  output wire [23:0]       DETECT_LIMIT,
  output wire [3:0]        OFFSET_REMOVAL_COEFFICIENT,
  output wire [9:0]        FIRST_CHANNEL_SAMPLE_SKEW,
  output wire              FIRST_CHANNEL_OFFSET_REMOVAL_OFF,
  output wire [1:0]        FIRST_CHANNEL_INPUT_SELECT,
  output wire              FILTER_ACTIVE,
  output wire [4:0]        FILTER_SHIFT,
  output wire [3:0]        INPUT_ONEHOT,
  output wire [23:0]       FIRST_CHANNEL_ZERO_TRIM
);
`include "adc_cfg_defines.vh"

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Merge new data into an old word under the two low byte strobes
  // Used for every register so byte writes behave the same everywhere
  function [15:0] lane_merge;
    input [15:0] old_w;
    input [15:0] new_w;
    input [1:0]  strb;
    begin
      lane_merge = old_w;
      if (strb[0])
      begin
        lane_merge[`F_LANE0] = new_w[`F_LANE0];
      end
      if (strb[1])
      begin
        lane_merge[`F_LANE1] = new_w[`F_LANE1];
      end
    end
  endfunction

  // ****************************************************************
  // Storage
  // ****************************************************************
  // Only defined fields own flops; reserved bits are constant zeros in
  // the read images, so a stray write can never make them read back one
  reg  [15:0]       detect_limit_upper_bits_r;          // Threshold high word
  reg  [7:0]        detect_limit_lower_byte_r;          // Threshold low byte
  reg  [3:0]        offset_removal_coefficient_r;       // Global filter code
  reg  [9:0]        first_channel_sample_skew_r;        // Signed skew
  reg               first_channel_offset_removal_off_r; // Local filter off
  reg  [1:0]        first_channel_input_select_r;       // Input mux code
  reg  [15:0]       zero_trim_upper_bits_r;             // Trim bits 23:8
  reg  [7:0]        zero_trim_lower_byte_r;             // Trim bits 7:0

  // ****************************************************************
  // Bus side wires
  // ****************************************************************
  // Strobes and index come from the access block, valid in the access phase
  wire              wr_en;       // Write commit strobe
  wire              rd_en;       // Read data capture strobe
  wire              hit;         // Address maps a register
  wire [`IDX_W-1:0] idx;         // Register index
  reg  [15:0]       rd_word;     // Image of addressed register
  wire [15:0]       img_limit_high;  // Register images as read
  wire [15:0]       img_limit_low;
  wire [15:0]       img_setup;
  wire [15:0]       img_trim_high;
  wire [15:0]       img_trim_low;
  wire [15:0]       wr_word;     // Merged write word

  // ****************************************************************
  // Bus access control
  // ****************************************************************

  // Handshake, decode and error answer
  // Ready rises in the second access cycle; a write lands on that edge,
  // while read data is taken one edge earlier so it stands with ready
  apb_access_ctrl #(
    .ADDR_W    (ADDR_W)
  ) u_access (
    .clk       (MCLK),
    .arst_n    (ARST_N),
    .clk_en    (CLK_EN),
    .psel      (PSEL),
    .penable   (PENABLE),
    .pwrite    (PWRITE),
    .paddr     (PADDR),
    .pready_r  (PREADY),
    .pslverr_r (PSLVERR),
    .wr_en     (wr_en),
    .rd_en     (rd_en),
    .hit       (hit),
    .idx       (idx)
  );

  // ****************************************************************
  // Register images
  // ****************************************************************

  // Images are built fresh each cycle from the field flops
  // Full high word of the threshold
  assign img_limit_high = detect_limit_upper_bits_r;

  // Low byte, reserved zeros, then global coefficient
  assign img_limit_low  = {detect_limit_lower_byte_r, 4'h0,
                           offset_removal_coefficient_r};

  // Skew, reserved zeros, local off bit, input select
  // Software writes zeros to 5:3; whatever it writes is dropped
  assign img_setup      = {first_channel_sample_skew_r, 3'h0,
                           first_channel_offset_removal_off_r,
                           first_channel_input_select_r};

  // Trim high word holds bits 23:8
  assign img_trim_high  = zero_trim_upper_bits_r;

  // Trim low byte, reserved byte reads zero
  assign img_trim_low   = {zero_trim_lower_byte_r, `RST_BYTE};

  // ****************************************************************
  // Read selection
  // ****************************************************************

  // Choose the image of the addressed register
  // An unmapped index reads zero; the access block flags the error
  always @*
  begin
    case (idx)
      `IDX_LIMIT_HIGH: rd_word = img_limit_high;
      `IDX_LIMIT_LOW:  rd_word = img_limit_low;
      `IDX_SETUP:      rd_word = img_setup;
      `IDX_TRIM_HIGH:  rd_word = img_trim_high;
      `IDX_TRIM_LOW:   rd_word = img_trim_low;
      default:         rd_word = `RST_WORD;  // Unmapped reads zero
    endcase
  end

  // Write word after applying byte strobes to the current image
  // A lane without its strobe keeps the stored bits; strobes 3:2 cover
  // the unused upper half of the data bus and are ignored
  assign wr_word = lane_merge(rd_word, PWDATA[`F_WORD], PSTRB[1:0]);

  // ****************************************************************
  // Read data flop
  // ****************************************************************

  // Captured one edge before ready; zero on an unmapped read
  // Holds between reads, so a slow master still finds the last word
  always @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      PRDATA <= `RST_BUS;
    end
    else if (CLK_EN && rd_en)
    begin
      if (hit)
      begin
        PRDATA <= {16'h0000, rd_word};
      end
      else
      begin
        PRDATA <= `RST_BUS;
      end
    end
  end

  // ****************************************************************
  // Register write
  // ****************************************************************

  // All fields reset to zero; reserved bits are never stored
  // Clock enable low freezes every field along with the handshake
  always @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      detect_limit_upper_bits_r          <= `RST_WORD;
      detect_limit_lower_byte_r          <= `RST_BYTE;
      offset_removal_coefficient_r       <= `RST_COEFF;
      first_channel_sample_skew_r        <= `RST_SKEW;
      first_channel_offset_removal_off_r <= 1'b0;
      first_channel_input_select_r       <= `RST_SEL;
      zero_trim_upper_bits_r             <= `RST_WORD;
      zero_trim_lower_byte_r             <= `RST_BYTE;
    end
    else if (CLK_EN && wr_en)
    begin
      case (idx)
        // Threshold high word, all sixteen bits
        `IDX_LIMIT_HIGH:
        begin
          detect_limit_upper_bits_r <= wr_word;
        end
        // Threshold low byte and global coefficient
        `IDX_LIMIT_LOW:
        begin
          detect_limit_lower_byte_r    <= wr_word[`F_LIMIT_LOWER];
          offset_removal_coefficient_r <= wr_word[`F_COEFF];
        end
        // Channel setup; bits 5:3 are dropped
        `IDX_SETUP:
        begin
          first_channel_sample_skew_r        <= wr_word[`F_SKEW];
          first_channel_offset_removal_off_r <= wr_word[`F_REMOVAL_OFF];
          first_channel_input_select_r       <= wr_word[`F_INPUT_SEL];
        end
        // Trim upper sixteen bits
        `IDX_TRIM_HIGH:
        begin
          zero_trim_upper_bits_r <= wr_word;
        end
        // Trim lower byte in the upper lane
        `IDX_TRIM_LOW:
        begin
          zero_trim_lower_byte_r <= wr_word[`F_TRIM_LOWER];
        end
        // Unmapped: nothing stored
        default:
        begin
          zero_trim_lower_byte_r <= zero_trim_lower_byte_r;
        end
      endcase
    end
  end

  // ****************************************************************
  // Filter and input decode
  // ****************************************************************

  // Effective filter for channel 0 and one-hot input select
  // Decoded values trail the fields by one cycle, so a consumer that
  // needs them aligned with a write must wait one extra edge
  channel_filter_decode u_decode (
    .clk            (MCLK),
    .arst_n         (ARST_N),
    .clk_en         (CLK_EN),
    .coeff          (offset_removal_coefficient_r),
    .removal_off    (first_channel_offset_removal_off_r),
    .input_sel      (first_channel_input_select_r),
    .filter_on_r    (FILTER_ACTIVE),
    .filter_shift_r (FILTER_SHIFT),
    .sel_onehot_r   (INPUT_ONEHOT)
  );

  // ****************************************************************
  // Field outputs
  // ****************************************************************

  // Every field output is a flop; nothing but wiring sits in the path
  // Threshold as one 24-bit value, high word first
  // The two words are not written atomically: update high then low
  assign DETECT_LIMIT = {detect_limit_upper_bits_r,
                         detect_limit_lower_byte_r};

  // Global coefficient code
  // Zero turns the filter off; each step up halves the coefficient
  assign OFFSET_REMOVAL_COEFFICIENT = offset_removal_coefficient_r;

  // Two's-complement skew in modulator cycles
  // Sign is kept as stored; the sampler sign-extends it as it needs
  assign FIRST_CHANNEL_SAMPLE_SKEW = first_channel_sample_skew_r;

  // Local filter disable bit
  // Overrides the global code for this channel alone
  assign FIRST_CHANNEL_OFFSET_REMOVAL_OFF = first_channel_offset_removal_off_r;

  // Raw input select code
  // 0 pins, 1 shorted, 2 positive test, 3 negative test
  assign FIRST_CHANNEL_INPUT_SELECT = first_channel_input_select_r;

  // Zero trim as one 24-bit value
  // High word holds bits 23:8, the low word's upper byte bits 7:0
  assign FIRST_CHANNEL_ZERO_TRIM = {zero_trim_upper_bits_r,
                                    zero_trim_lower_byte_r};

endmodule // adc_cfg_regs
`default_nettype wire

// [test/adc_cfg_regs_sva.sv]
`default_nettype none
// ****************************************************************
// Checker: bus timing, field updates, decoded outputs
// ****************************************************************
// Assumes the clock enable stays high
module adc_cfg_regs_sva #(
  parameter ADDR_W = 8
) (
  input wire logic              MCLK,
  input wire logic              ARST_N,
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0]       PWDATA,
  input wire logic [3:0]        PSTRB,
  input wire logic [31:0]       PRDATA,
  input wire logic              PREADY,
  input wire logic              PSLVERR,
  input wire logic [23:0]       DETECT_LIMIT,
  input wire logic [3:0]        OFFSET_REMOVAL_COEFFICIENT,
  input wire logic [9:0]        FIRST_CHANNEL_SAMPLE_SKEW,
  input wire logic              FIRST_CHANNEL_OFFSET_REMOVAL_OFF,
  input wire logic [1:0]        FIRST_CHANNEL_INPUT_SELECT,
  input wire logic              FILTER_ACTIVE,
  input wire logic [4:0]        FILTER_SHIFT,
  input wire logic [3:0]        INPUT_ONEHOT,
  input wire logic [23:0]       FIRST_CHANNEL_ZERO_TRIM
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  // Address hits one of the five words
  wire mapped = PADDR inside {8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C};
  // Completed write with both low byte lanes
  wire full_wr = PREADY && PWRITE && PSTRB[1:0] == 2'b11;
  a_one_wait: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY)
    else $error("ready not after one wait state");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_err_map: assert property (PREADY |-> PSLVERR == !mapped)
    else $error("error answer does not match address");
  a_limit_write: assert property (full_wr && PADDR == 8'h1C |=>
    DETECT_LIMIT[23:8] == $past(PWDATA[15:0])) else $error("limit high not stored");
  a_limit_hold: assert property (!(PREADY && PWRITE && PADDR == 8'h1C) |=>
    $stable(DETECT_LIMIT[23:8])) else $error("limit high changed");
  a_low_write: assert property (full_wr && PADDR == 8'h20 |=> {DETECT_LIMIT[7:0],
    OFFSET_REMOVAL_COEFFICIENT} == {$past(PWDATA[15:8]), $past(PWDATA[3:0])})
    else $error("low word not stored");
  a_setup_write: assert property (full_wr && PADDR == 8'h24 |=>
    {FIRST_CHANNEL_SAMPLE_SKEW, FIRST_CHANNEL_OFFSET_REMOVAL_OFF, FIRST_CHANNEL_INPUT_SELECT} ==
    {$past(PWDATA[15:6]), $past(PWDATA[2:0])}) else $error("setup not stored");
  a_trim_write: assert property (full_wr && PADDR == 8'h2C |=>
    FIRST_CHANNEL_ZERO_TRIM[7:0] == $past(PWDATA[15:8])) else $error("trim low bad");
  a_rsvd_read: assert property (PREADY && !PWRITE |-> PRDATA[31:16] == 16'h0000
    && !(PADDR == 8'h20 && PRDATA[7:4] != 4'h0) && !(PADDR == 8'h24 && PRDATA[5:3] != 3'h0)
    && !(PADDR == 8'h2C && PRDATA[7:0] != 8'h00)) else $error("reserved bits read nonzero");
  a_filter_on: assert property (FILTER_ACTIVE ==
    ($past(OFFSET_REMOVAL_COEFFICIENT) != 4'h0 && !$past(FIRST_CHANNEL_OFFSET_REMOVAL_OFF)))
    else $error("filter enable wrong");
  a_filter_shift: assert property (FILTER_SHIFT ==
    (($past(OFFSET_REMOVAL_COEFFICIENT) != 4'h0 && !$past(FIRST_CHANNEL_OFFSET_REMOVAL_OFF)) ?
    {1'b0, $past(OFFSET_REMOVAL_COEFFICIENT)} + 5'h01 : 5'h00)) else $error("shift wrong");
  a_onehot: assert property (INPUT_ONEHOT == 4'h1 << $past(FIRST_CHANNEL_INPUT_SELECT))
    else $error("input select decode wrong");
  cover property (PREADY && PSLVERR);
  cover property (PREADY ##1 PSEL && !PENABLE);
  cover property (FILTER_ACTIVE && FILTER_SHIFT == 5'h10);
endmodule // adc_cfg_regs_sva

bind adc_cfg_regs adc_cfg_regs_sva #(.ADDR_W(ADDR_W)) i_adc_cfg_regs_sva (
  .MCLK(MCLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .DETECT_LIMIT(DETECT_LIMIT),
  .OFFSET_REMOVAL_COEFFICIENT(OFFSET_REMOVAL_COEFFICIENT),
  .FIRST_CHANNEL_SAMPLE_SKEW(FIRST_CHANNEL_SAMPLE_SKEW),
  .FIRST_CHANNEL_OFFSET_REMOVAL_OFF(FIRST_CHANNEL_OFFSET_REMOVAL_OFF),
  .FIRST_CHANNEL_INPUT_SELECT(FIRST_CHANNEL_INPUT_SELECT), .FILTER_ACTIVE(FILTER_ACTIVE),
  .FILTER_SHIFT(FILTER_SHIFT), .INPUT_ONEHOT(INPUT_ONEHOT),
  .FIRST_CHANNEL_ZERO_TRIM(FIRST_CHANNEL_ZERO_TRIM)
);
`default_nettype wire

// [test/test_adc_cfg_regs.sv]
`default_nettype none
module test_adc_cfg_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic        MCLK    = 1'b0;      // 40 MHz clock
  logic        ARST_N  = 1'b0;      // Reset, active low
  logic        PSEL    = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE  = 1'b0;
  logic [7:0]  PADDR   = 8'h00;
  logic [31:0] PWDATA  = 32'h0000_0000;
  logic [3:0]  PSTRB   = 4'h0;
  wire  [31:0] PRDATA;
  wire         PREADY, PSLVERR, FIRST_CHANNEL_OFFSET_REMOVAL_OFF, FILTER_ACTIVE;
  wire  [23:0] DETECT_LIMIT, FIRST_CHANNEL_ZERO_TRIM;
  wire  [3:0]  OFFSET_REMOVAL_COEFFICIENT, INPUT_ONEHOT;
  wire  [9:0]  FIRST_CHANNEL_SAMPLE_SKEW;
  wire  [1:0]  FIRST_CHANNEL_INPUT_SELECT;
  wire  [4:0]  FILTER_SHIFT;
  int          n_fail     = 0;      // Mismatches
  int          num_checks = 0;      // Comparisons
  logic [15:0] model [7:11];        // Expected register words
  logic [15:0] rwm [7:11] = '{16'hFFFF, 16'hFF0F, 16'hFFC7, 16'hFFFF, 16'hFF00};
  logic [31:0] rdat;                // Last read data
  logic        rerr;                // Last error answer

  adc_cfg_regs i_adc_cfg_regs (
    .MCLK(MCLK), .ARST_N(ARST_N), .CLK_EN(1'b1), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .DETECT_LIMIT(DETECT_LIMIT),
    .OFFSET_REMOVAL_COEFFICIENT(OFFSET_REMOVAL_COEFFICIENT),
    .FIRST_CHANNEL_SAMPLE_SKEW(FIRST_CHANNEL_SAMPLE_SKEW),
    .FIRST_CHANNEL_OFFSET_REMOVAL_OFF(FIRST_CHANNEL_OFFSET_REMOVAL_OFF),
    .FIRST_CHANNEL_INPUT_SELECT(FIRST_CHANNEL_INPUT_SELECT), .FILTER_ACTIVE(FILTER_ACTIVE),
    .FILTER_SHIFT(FILTER_SHIFT), .INPUT_ONEHOT(INPUT_ONEHOT),
    .FIRST_CHANNEL_ZERO_TRIM(FIRST_CHANNEL_ZERO_TRIM)
  );

  // Clock generator
  always #12.5 MCLK = ~MCLK;

  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  // Compare one value, count and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; keep leaves select high for a back-to-back setup
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic keep);
    PSEL   <= 1'b1;
    PWRITE <= wr;
    PADDR  <= a;
    PWDATA <= d;
    PSTRB  <= s;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge MCLK);
    end
    while (PREADY !== 1'b1);
    rdat = PRDATA;
    rerr = PSLVERR;
    PENABLE <= 1'b0;
    if (!keep)
    begin
      PSEL <= 1'b0;
      @(posedge MCLK);
    end
  endtask

  // Write a register by index and track the expected word
  task automatic wreg(input int i, input logic [15:0] d, input logic [3:0] s, input logic keep);
    logic [15:0] m;
    m = {{8{s[1]}}, {8{s[0]}}} & rwm[i];
    apb(1'b1, 8'(4 * i), {16'hDEAD, d}, s, keep);
    model[i] = (model[i] & ~m) | (d & m);
  endtask

  // Read a register by index and compare with the expected word
  task automatic rchk(input int i);
    apb(1'b0, 8'(4 * i), 32'h0000_0000, 4'h0, 1'b0);
    chk(rdat, {16'h0000, model[i]});
    chk({31'h0, rerr}, 32'h0000_0000);
  endtask

  // Verdict and end of run
  task automatic final_report;
    if (n_fail == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    foreach (model[i])
      model[i] = 16'h0000;
    repeat (2) @(posedge MCLK);
    ARST_N <= 1'b1;
    @(posedge MCLK);
    chk({4'h0, DETECT_LIMIT, INPUT_ONEHOT}, 32'h0000_0001);
    for (int i = 7; i <= 11; i++)
      rchk(i);
    // All ones back to back, zeros in reserved bits except the trim low word, which gets all ones
    for (int i = 7; i <= 11; i++)
      wreg(i, (i == 11) ? 16'hFFFF : rwm[i], 4'hF, i != 11);
    for (int i = 7; i <= 11; i++)
      rchk(i);
    // Single byte lanes
    wreg(7, 16'h1234, 4'h1, 1'b0);
    wreg(7, 16'h5600, 4'h2, 1'b0);
    rchk(7);
    // Unmapped and misaligned places answer with an error and change nothing
    foreach (rwm[j])
    begin
      apb(1'b1, 8'(4 * j + 64), 32'h0000_0000, 4'hF, 1'b0);
      chk({31'h0, rerr}, 32'h0000_0001);
      apb(1'b0, 8'(4 * j + 1), 32'h0000_0000, 4'h0, 1'b0);
      chk({rdat[30:0], rerr}, 32'h0000_0001);
    end
    for (int i = 7; i <= 11; i++)
      rchk(i);
    // Every coefficient code, with and without the channel override
    for (int off = 0; off < 2; off++)
    begin
      wreg(9, {13'h0000, off[0], 2'b00}, 4'hF, 1'b0);
      for (int c = 0; c < 16; c++)
      begin
        wreg(8, {8'hA5, 4'h0, c[3:0]}, 4'hF, 1'b0);
        @(posedge MCLK);
        chk({26'h0, FILTER_ACTIVE, FILTER_SHIFT}, {26'h0, c != 0 && off == 0,
            (c != 0 && off == 0) ? 5'(c + 1) : 5'h00});
        chk({DETECT_LIMIT, OFFSET_REMOVAL_COEFFICIENT, 4'h0},
            {model[7], model[8][15:8], model[8][3:0], 4'h0});
      end
    end
    // Every input selection with boundary skews
    for (int s = 0; s < 4; s++)
    begin
      wreg(9, {s[0] ? 10'h200 : 10'h1FF, 3'h0, 1'b0, s[1:0]}, 4'hF, 1'b0);
      @(posedge MCLK);
      chk({INPUT_ONEHOT, FIRST_CHANNEL_SAMPLE_SKEW, FIRST_CHANNEL_OFFSET_REMOVAL_OFF,
           FIRST_CHANNEL_INPUT_SELECT}, {4'h1 << s, model[9][15:6], model[9][2:0]});
      rchk(9);
    end
    // Offset trim value spread over two words
    wreg(10, 16'hC3A5, 4'hF, 1'b1);
    wreg(11, 16'h7E81, 4'hF, 1'b0);
    @(posedge MCLK);
    chk({8'h00, FIRST_CHANNEL_ZERO_TRIM}, {8'h00, model[10], model[11][15:8]});
    // Reset in mid-run returns every field to zero
    ARST_N <= 1'b0;
    repeat (2) @(posedge MCLK);
    ARST_N <= 1'b1;
    foreach (model[i])
      model[i] = 16'h0000;
    @(posedge MCLK);
    chk({FIRST_CHANNEL_ZERO_TRIM, INPUT_ONEHOT, 3'h0, FILTER_ACTIVE}, 32'h0000_0010);
    for (int i = 7; i <= 11; i++)
      rchk(i);
    final_report;
  end

  // Watchdog against a hung handshake
  initial
  begin
    repeat (5000) @(posedge MCLK);
    n_fail++;
    final_report;
  end
endmodule // test_adc_cfg_regs
`default_nettype wire
